// ===== src/prepaid_card_eeprom.sv
`timescale 1ns/1ps
`include "card_eeprom_defines.svh"


module prepaid_card_eeprom #(
    parameter int          BIT_CYCLES     = `CLK_FREQ_HZ / `BAUD_RATE,
    parameter int          POWERUP_CYCLES = (`CLK_FREQ_HZ / 1000000) * `POWERUP_TIME_US,
    parameter int          WRITE_CYCLES   = (`CLK_FREQ_HZ / 1000000) * `WRITE_TIME_US,
    parameter logic [31:0] PRODUCER_DATA  = 32'h0123_4567  // Arbitrary chip data
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic chipSelect,
    input  wire logic dataLineIn,
    output logic      dataLineOut,
    output logic      dataLineOe,
    output logic      writeBusy
);

    localparam int GLITCH_CYCLES =
        (`GLITCH_TIME_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000;
    localparam int TW = $clog2(WRITE_CYCLES + 1);
    localparam int PW = $clog2(POWERUP_CYCLES + 1);

    initial if (WRITE_CYCLES < BIT_CYCLES || POWERUP_CYCLES < 1)
        $error("WRITE_CYCLES below BIT_CYCLES or POWERUP_CYCLES zero");

    logic                         csClean;
    logic                         lineClean;
    logic                         rxValid;
    logic [7:0]                   rxData;
    card_eeprom_pkg::state_e      state_reg;
    card_eeprom_pkg::state_e      state_next;
    card_eeprom_pkg::cmd_e        cmd_reg;
    card_eeprom_pkg::cmd_bytes_s  bytes_reg;
    logic [TW-1:0]                timer_reg;
    logic [PW-1:0]                powerCnt_reg;
    logic                         ready_reg;
    logic                         locked_reg;
    logic [9:0]                   txShift_reg;
    logic [3:0]                   txBits_reg;
    logic                         lineOe_reg;
    logic                         busy_reg;
    logic [7:0]                   mem [`MEM_BYTES];

    // Chip select and data line through synchroniser and filter
    line_filter #(.STABLE_CYCLES(1)) u_csFilter (
        .clk      (clk),
        .reset_n  (reset_n),
        .rawIn    (chipSelect),
        .cleanOut (csClean)
    );

    line_filter #(.STABLE_CYCLES(GLITCH_CYCLES)) u_lineFilter (
        .clk      (clk),
        .reset_n  (reset_n),
        .rawIn    (dataLineIn),
        .cleanOut (lineClean)
    );

    // Receiver is held off while deselected, writing or sending
    wire rxClear = !csClean || (state_reg == card_eeprom_pkg::ST_WRITE)
                 || (state_reg == card_eeprom_pkg::ST_SEND);

    serial_byte_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
        .clk       (clk),
        .reset_n   (reset_n),
        .clear     (rxClear),
        .lineIn    (lineClean),
        .byteValid (rxValid),
        .byteData  (rxData)
    );

    // Section checks on a 16-bit address
    function automatic logic in_span(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
        in_span = (a >= lo) && (a <= hi);
    endfunction

    // Array read with producer bytes from the fixed pattern
    function automatic logic [7:0] read_byte(input logic [15:0] a);
        logic [7:0] b;
        b = `ERASED_BYTE;
        if (a <= `PRODUCER_LAST)
            b = PRODUCER_DATA[8*a[1:0] +: 8];
        else if (a <= `USER_LAST)
            b = mem[a[6:0]];
        read_byte = b;
    endfunction

    // Command and address decode
    wire [3:0]  cmdField   = rxData[7:4];
    wire [15:0] fullAddr   = {bytes_reg.firstAddressByte, bytes_reg.secondAddressByte};
    wire [6:0]  memIdx     = bytes_reg.secondAddressByte[6:0];
    wire        issuerOk   = in_span(fullAddr, `ISSUER_FIRST, `ISSUER_LAST)
                           && !locked_reg;
    wire        freeOk     = in_span(fullAddr, `USER_FIRST, `USER_LAST);
    wire        writeOk    = (cmd_reg == card_eeprom_pkg::CMD_ISSUER_WRITE)
                           ? issuerOk : freeOk;
    wire [15:0] storedVal  = {mem[`COUNT_HI_ADDR], mem[`COUNT_LO_ADDR]};
    wire [15:0] newVal     = {rxData, bytes_reg.valueLowByte};
    wire        valueOk    = newVal < storedVal;
    wire        enterWrite = (state_next == card_eeprom_pkg::ST_WRITE)
                           && (state_reg != card_eeprom_pkg::ST_WRITE);
    wire        enterSend  = (state_next == card_eeprom_pkg::ST_SEND)
                           && (state_reg != card_eeprom_pkg::ST_SEND);
    wire        timerDone  = (timer_reg == '0);
    wire        commit     = (state_reg == card_eeprom_pkg::ST_WRITE) && timerDone;
    wire        sendDone   = (state_reg == card_eeprom_pkg::ST_SEND) && timerDone
                           && (txBits_reg == 4'h0);
    wire        cmdTaken   = rxValid && ready_reg;

    // Next state of the command sequencer
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            card_eeprom_pkg::ST_CMD:
                if (cmdTaken)
                begin
                    case (cmdField)
                        card_eeprom_pkg::CMD_READ,
                        card_eeprom_pkg::CMD_ISSUER_WRITE,
                        card_eeprom_pkg::CMD_FREE_WRITE:
                            state_next = card_eeprom_pkg::ST_FIRST_ADDRESS_BYTE;
                        card_eeprom_pkg::CMD_VALUE_WRITE:
                            state_next = card_eeprom_pkg::ST_VALUE_LOW_BYTE;
                        card_eeprom_pkg::CMD_LOCK:
                            state_next = locked_reg ? card_eeprom_pkg::ST_CMD
                                                    : card_eeprom_pkg::ST_WRITE;
                        default:
                            state_next = card_eeprom_pkg::ST_CMD;
                    endcase
                end
            card_eeprom_pkg::ST_FIRST_ADDRESS_BYTE:
                if (rxValid)
                    state_next = card_eeprom_pkg::ST_SECOND_ADDRESS_BYTE;
            card_eeprom_pkg::ST_SECOND_ADDRESS_BYTE:
                if (rxValid)
                    state_next = (cmd_reg == card_eeprom_pkg::CMD_READ)
                               ? card_eeprom_pkg::ST_SEND
                               : card_eeprom_pkg::ST_VALUE_LOW_BYTE;
            card_eeprom_pkg::ST_VALUE_LOW_BYTE:
                if (rxValid)
                begin
                    if (cmd_reg == card_eeprom_pkg::CMD_VALUE_WRITE)
                        state_next = card_eeprom_pkg::ST_VALUE_HIGH_BYTE;
                    else
                        state_next = writeOk ? card_eeprom_pkg::ST_WRITE
                                             : card_eeprom_pkg::ST_CMD;
                end
            card_eeprom_pkg::ST_VALUE_HIGH_BYTE:
                if (rxValid)
                    state_next = valueOk ? card_eeprom_pkg::ST_WRITE
                                         : card_eeprom_pkg::ST_CMD;
            card_eeprom_pkg::ST_WRITE:
                if (timerDone)
                    state_next = card_eeprom_pkg::ST_CMD;
            card_eeprom_pkg::ST_SEND:
                if (sendDone)
                    state_next = card_eeprom_pkg::ST_CMD;
            default:
                state_next = card_eeprom_pkg::ST_CMD;
        endcase
    end

    // State, command and gathered bytes; deselect resets only the state to ST_CMD
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= card_eeprom_pkg::ST_CMD;
            cmd_reg   <= card_eeprom_pkg::CMD_IDLE;
            bytes_reg <= '0;
        end
        else if (!csClean)
            state_reg <= card_eeprom_pkg::ST_CMD;
        else
        begin
            state_reg <= state_next;
            if (cmdTaken && state_reg == card_eeprom_pkg::ST_CMD)
                cmd_reg <= card_eeprom_pkg::cmd_e'(cmdField);
            if (rxValid && state_reg == card_eeprom_pkg::ST_FIRST_ADDRESS_BYTE)
                bytes_reg.firstAddressByte <= rxData;
            if (rxValid && state_reg == card_eeprom_pkg::ST_SECOND_ADDRESS_BYTE)
                bytes_reg.secondAddressByte <= rxData;
            if (rxValid && state_reg == card_eeprom_pkg::ST_VALUE_LOW_BYTE)
                bytes_reg.valueLowByte <= rxData;
            if (rxValid && state_reg == card_eeprom_pkg::ST_VALUE_HIGH_BYTE)
                bytes_reg.valueHighByte <= rxData;
        end
    end

    // Power-up hold-off counter
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            powerCnt_reg <= '0;
            ready_reg    <= 1'b0;
        end
        else if (!ready_reg)
        begin
            powerCnt_reg <= powerCnt_reg + PW'(1);
            ready_reg    <= (powerCnt_reg == PW'(POWERUP_CYCLES - 1));
        end
    end

    // Shared timer: write duration and transmit bit time
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            timer_reg <= '0;
        else if (!csClean)
            timer_reg <= '0;
        else if (enterWrite)
            timer_reg <= TW'(WRITE_CYCLES - 1);
        else if (enterSend || (state_reg == card_eeprom_pkg::ST_SEND
                               && timerDone && txBits_reg != 4'h0))
            timer_reg <= TW'(BIT_CYCLES - 1);
        else if (!timerDone)
            timer_reg <= timer_reg - TW'(1);
    end

    // Transmitter: start bit, data LSB first, stop bit
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            txShift_reg <= 10'h3FF;
            txBits_reg  <= 4'h0;
            lineOe_reg  <= 1'b0;
        end
        else if (!csClean || sendDone)
        begin
            txShift_reg <= 10'h3FF;
            txBits_reg  <= 4'h0;
            lineOe_reg  <= 1'b0;
        end
        else if (enterSend)
        begin
            txShift_reg <= {`LINE_IDLE, read_byte({bytes_reg.firstAddressByte, rxData}),
                            1'b0};
            txBits_reg  <= 4'h9;
            lineOe_reg  <= 1'b1;
        end
        else if (state_reg == card_eeprom_pkg::ST_SEND && timerDone)
        begin
            txShift_reg <= {`LINE_IDLE, txShift_reg[9:1]};
            txBits_reg  <= txBits_reg - 4'h1;
        end
    end

    // Busy flag and lock bit
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busy_reg   <= 1'b0;
            locked_reg <= 1'b0;
        end
        else
        begin
            busy_reg <= csClean && (state_next == card_eeprom_pkg::ST_WRITE);
            if (commit && csClean && cmd_reg == card_eeprom_pkg::CMD_LOCK)
                locked_reg <= 1'b1;
        end
    end

    // Array starts erased; commit at end of the self-timed write
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < `MEM_BYTES; i++)
                mem[i] <= `ERASED_BYTE;
        end
        else if (commit && csClean)
        begin
            case (cmd_reg)
                card_eeprom_pkg::CMD_ISSUER_WRITE,
                card_eeprom_pkg::CMD_FREE_WRITE:
                    mem[memIdx] <= bytes_reg.valueLowByte;
                card_eeprom_pkg::CMD_VALUE_WRITE:
                begin
                    mem[`COUNT_LO_ADDR]  <= bytes_reg.valueLowByte;
                    mem[`BACKUP_LO_ADDR] <= bytes_reg.valueLowByte;
                    mem[`COUNT_HI_ADDR]  <= bytes_reg.valueHighByte;
                    mem[`BACKUP_HI_ADDR] <= bytes_reg.valueHighByte;
                end
                default:
                    ;
            endcase
        end
    end

    assign dataLineOut = txShift_reg[0];
    assign dataLineOe  = lineOe_reg;
    assign writeBusy   = busy_reg;

endmodule // prepaid_card_eeprom

// ===== src/card_eeprom_defines.svh
`ifndef CARD_EEPROM_DEFINES_SVH
`define CARD_EEPROM_DEFINES_SVH

// Clock and link timing in their own units
`define CLK_FREQ_HZ      100000000
`define BAUD_RATE        9600
`define GLITCH_TIME_NS   30
`define POWERUP_TIME_US  1000
`define WRITE_TIME_US    10000

// Memory sections
`define MEM_BYTES        128
`define PRODUCER_LAST    16'h0003
`define ISSUER_FIRST     16'h0004
`define ISSUER_LAST      16'h000F
`define COUNT_LO_ADDR    7'h10
`define COUNT_HI_ADDR    7'h11
`define BACKUP_LO_ADDR   7'h12
`define BACKUP_HI_ADDR   7'h13
`define USER_FIRST       16'h0014
`define USER_LAST        16'h007F

// Reset values
`define ERASED_BYTE      8'hFF
`define LINE_IDLE        1'b1

`endif

// ===== src/card_eeprom_pkg.sv
package card_eeprom_pkg;

    // Command codes in the upper four bits of the command byte
    typedef enum logic [3:0] {
        CMD_READ         = 4'h8,
        CMD_ISSUER_WRITE = 4'h4,
        CMD_VALUE_WRITE  = 4'hC,
        CMD_FREE_WRITE   = 4'h1,
        CMD_LOCK         = 4'h0,
        CMD_IDLE         = 4'hF
    } cmd_e;

    // Command sequencer states
    typedef enum logic [2:0] {
        ST_CMD   = 3'h0,
        ST_FIRST_ADDRESS_BYTE = 3'h1,
        ST_SECOND_ADDRESS_BYTE = 3'h2,
        ST_VALUE_LOW_BYTE = 3'h3,
        ST_VALUE_HIGH_BYTE = 3'h4,
        ST_WRITE = 3'h5,
        ST_SEND  = 3'h6
    } state_e;

    // Bytes gathered for one command
    typedef struct packed {
        logic [7:0] firstAddressByte;
        logic [7:0] secondAddressByte;
        logic [7:0] valueLowByte;
        logic [7:0] valueHighByte;
    } cmd_bytes_s;

endpackage

// ===== src/line_filter.sv
`timescale 1ns/1ps

module line_filter #(
    parameter int STABLE_CYCLES = 3
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic rawIn,
    output logic      cleanOut
);

    initial if (STABLE_CYCLES < 1) $error("STABLE_CYCLES must be at least 1");

    localparam int CW = $clog2(STABLE_CYCLES + 1);

    logic          sync1_reg;
    logic          sync2_reg;
    logic [CW-1:0] stable_reg;
    logic          clean_reg;

    // Two-stage synchroniser, first stage feeds only the second
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end
        else
        begin
            sync1_reg <= rawIn;
            sync2_reg <= sync1_reg;
        end
    end

    // Level must hold for STABLE_CYCLES before it is passed on
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stable_reg <= '0;
            clean_reg  <= 1'b1;
        end
        else if (sync2_reg == clean_reg)
            stable_reg <= '0;
        else if (stable_reg == CW'(STABLE_CYCLES - 1))
        begin
            stable_reg <= '0;
            clean_reg  <= sync2_reg;
        end
        else
            stable_reg <= stable_reg + CW'(1);
    end

    assign cleanOut = clean_reg;

endmodule // line_filter

// ===== src/serial_byte_rx.sv
`timescale 1ns/1ps

module serial_byte_rx #(
    parameter int BIT_CYCLES = 10416
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       clear,
    input  wire logic       lineIn,
    output logic            byteValid,
    output logic [7:0]      byteData
);

    initial if (BIT_CYCLES < 4) $error("BIT_CYCLES must be at least 4");

    localparam int CW = $clog2(BIT_CYCLES);

    logic          active_reg;
    logic [CW-1:0] tick_reg;
    logic [3:0]    bitIdx_reg;
    logic [7:0]    shift_reg;
    logic          valid_reg;

    wire tickDone = (tick_reg == '0);

    // Start bit checked at mid-bit, then 8 data bits LSB first, then stop bit
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            active_reg <= 1'b0;
            tick_reg   <= '0;
            bitIdx_reg <= 4'h0;
            shift_reg  <= 8'h00;
            valid_reg  <= 1'b0;
        end
        else if (clear)
        begin
            active_reg <= 1'b0;
            valid_reg  <= 1'b0;
        end
        else
        begin
            valid_reg <= 1'b0;
            if (!active_reg)
            begin
                if (!lineIn)
                begin
                    active_reg <= 1'b1;
                    tick_reg   <= CW'(BIT_CYCLES / 2);
                    bitIdx_reg <= 4'h0;
                end
            end
            else if (!tickDone)
                tick_reg <= tick_reg - CW'(1);
            else if (bitIdx_reg == 4'h0)
            begin
                active_reg <= !lineIn;                // Glitch start dropped
                tick_reg   <= CW'(BIT_CYCLES - 1);
                bitIdx_reg <= 4'h1;
            end
            else if (bitIdx_reg != 4'h9)
            begin
                shift_reg  <= {lineIn, shift_reg[7:1]};
                tick_reg   <= CW'(BIT_CYCLES - 1);
                bitIdx_reg <= bitIdx_reg + 4'h1;
            end
            else
            begin
                active_reg <= 1'b0;
                valid_reg  <= lineIn;
            end
        end
    end

    assign byteValid = valid_reg;
    assign byteData  = shift_reg;

endmodule // serial_byte_rx

// ===== verification/card_host_model.sv
`timescale 1ns/1ps
module card_host_model #(
    parameter int BIT_CYCLES = 16
) (
    input  wire logic clk,
    input  wire logic lineLevel,
    output logic      hostOe,
    output logic      hostBit
);
    // Line released at time zero
    initial
    begin
        hostOe = 1'b0;
        hostBit = 1'b1;
    end
    // Start, eight bits LSB first, stop left to the pull-up
    task automatic sendByte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk);
            hostOe <= (i < 9);
            hostBit <= f[i];
            repeat (BIT_CYCLES - 1) @(posedge clk);
        end
    endtask
    // Reply byte, sampled mid-bit
    task automatic recvByte(output logic [7:0] b);
        int n;
        b = 8'hXX;
        n = 0;
        while ((hostOe || lineLevel) && n < 40 * BIT_CYCLES)
        begin
            @(posedge clk);
            n++;
        end
        if (n < 40 * BIT_CYCLES)
        begin
            repeat (BIT_CYCLES / 2) @(posedge clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CYCLES) @(posedge clk);
                b[i] = lineLevel;
            end
        end
    endtask
endmodule // card_host_model

// ===== verification/prepaid_card_eeprom_checker.sv
`timescale 1ns/1ps
module prepaid_card_eeprom_checker #(
    parameter int BIT_CYCLES     = 10416,
    parameter int POWERUP_CYCLES = 100000,
    parameter int WRITE_CYCLES   = 1000000
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic chipSelect,
    input  wire logic dataLineIn,
    input  wire logic dataLineOut,
    input  wire logic dataLineOe,
    input  wire logic writeBusy
);
    int busyCnt;
    int oeCnt;
    int pwrCnt;
    // Cycle counters
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busyCnt <= 0;
            oeCnt <= 0;
            pwrCnt <= 0;
        end
        else
        begin
            busyCnt <= writeBusy ? busyCnt + 1 : 0;
            oeCnt <= dataLineOe ? oeCnt + 1 : 0;
            pwrCnt <= (pwrCnt < POWERUP_CYCLES) ? pwrCnt + 1 : pwrCnt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_cs_release: assert property (!chipSelect [*5] |-> !dataLineOe && !writeBusy)
        else $error("chip select low did not idle device");
    a_busy_time: assert property (disable iff (!reset_n || !chipSelect)
        $fell(writeBusy) |-> busyCnt == WRITE_CYCLES) else $error("write time wrong");
    a_busy_quiet: assert property (writeBusy |-> !dataLineOe)
        else $error("line driven during write");
    a_start_low: assert property ($rose(dataLineOe) |-> !dataLineOut)
        else $error("reply start bit not low");
    a_stop_high: assert property (disable iff (!reset_n || !chipSelect)
        $fell(dataLineOe) |-> $past(dataLineOut)) else $error("reply stop bit not high");
    a_reply_len: assert property (disable iff (!reset_n || !chipSelect)
        $fell(dataLineOe) |-> oeCnt == 10 * BIT_CYCLES) else $error("reply length wrong");
    a_bit_steady: assert property (dataLineOe && $past(dataLineOe) && $changed(dataLineOut)
        |-> oeCnt % BIT_CYCLES == 0) else $error("reply bit edge off");
    a_idle_high: assert property (!dataLineOe |-> dataLineOut)
        else $error("released output not high");
    a_powerup_quiet: assert property (pwrCnt < POWERUP_CYCLES
        |-> !writeBusy && !dataLineOe) else $error("command ran during power-up");
    c_write: cover property ($fell(writeBusy));
    c_reply: cover property ($fell(dataLineOe));
    c_abort: cover property (writeBusy && !chipSelect);
    c_command: cover property ($fell(dataLineIn) && !dataLineOe);
endmodule // prepaid_card_eeprom_checker
bind prepaid_card_eeprom prepaid_card_eeprom_checker #(.BIT_CYCLES(BIT_CYCLES),
    .POWERUP_CYCLES(POWERUP_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) i_checker (.clk(clk),
    .reset_n(reset_n), .chipSelect(chipSelect), .dataLineIn(dataLineIn),
    .dataLineOut(dataLineOut), .dataLineOe(dataLineOe), .writeBusy(writeBusy));

// ===== verification/tb_prepaid_card_eeprom.sv
`timescale 1ns/1ps
module tb_prepaid_card_eeprom;
    localparam int BIT = 16;
    localparam int PWR = 400;
    localparam int WR = 400;
    localparam logic [31:0] PROD = 32'h0123_4567; // Chip data as built, arbitrary
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        chipSelect = 1'b1;
    logic        dataLineOut, dataLineOe, writeBusy, hostOe, hostBit, locked;
    wire         lineLevel;
    logic [7:0]  mem [128];
    logic [7:0]  got, r, s;
    logic [31:0] seed = 32'h0000_0015;
    int          mismatches = 0;
    int          samplesChecked = 0;
    int          cycles = 0;
    logic [6:0]  rdList [8] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h10, 7'h14, 7'h7F};
    logic [10:0] corner [8] = '{{4'h1, 7'h00}, {4'h1, 7'h13}, {4'h1, 7'h14}, {4'h1, 7'h7F},
                                {4'h4, 7'h03}, {4'h4, 7'h04}, {4'h4, 7'h0F}, {4'h4, 7'h10}};
    always #5 clk = ~clk;
    // Shared line with pull-up
    assign lineLevel = dataLineOe ? dataLineOut : (hostOe ? hostBit : 1'b1);
    prepaid_card_eeprom #(.BIT_CYCLES(BIT), .POWERUP_CYCLES(PWR), .WRITE_CYCLES(WR))
        i_prepaid_card_eeprom (.clk(clk), .reset_n(reset_n),
        .chipSelect(chipSelect), .dataLineIn(lineLevel), .dataLineOut(dataLineOut),
        .dataLineOe(dataLineOe), .writeBusy(writeBusy));
    // Host default bit time equals BIT
    card_host_model host (.clk(clk), .lineLevel(lineLevel),
        .hostOe(hostOe), .hostBit(hostBit));
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    // Whether a write command may change this byte
    function automatic logic allowed(input logic [3:0] op, input logic [6:0] a);
        if (op == card_eeprom_pkg::CMD_ISSUER_WRITE)
            return !locked && a >= 7'h04 && a <= 7'h0F;
        return op == card_eeprom_pkg::CMD_FREE_WRITE && a >= 7'h14;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 80000)
        begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic sendCmd(input logic [3:0] op);
        r = rnd();
        host.sendByte({op, r[3:0]});
    endtask
    task automatic expectBusy(input logic exp);
        int n;
        n = 0;
        repeat (2) @(posedge clk);
        check({7'h00, writeBusy}, {7'h00, exp});
        while (writeBusy && n < 2 * WR)
        begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
    endtask
    task automatic readByte(input logic [6:0] a);
        sendCmd(card_eeprom_pkg::CMD_READ);
        host.sendByte(8'h00);
        fork
            host.sendByte({1'b0, a});
            host.recvByte(got);
        join
        repeat (2 * BIT) @(posedge clk);
        check(got, mem[a]);
    endtask
    task automatic doWrite(input logic [3:0] op, input logic [6:0] a, input logic [7:0] d);
        logic ok;
        ok = allowed(op, a);
        sendCmd(op);
        host.sendByte(8'h00);
        host.sendByte({1'b0, a});
        host.sendByte(d);
        expectBusy(ok);
        if (ok)
            mem[a] = d;
        readByte(a);
    endtask
    task automatic doValue(input logic [15:0] v);
        logic ok;
        ok = v < {mem[17], mem[16]};
        sendCmd(card_eeprom_pkg::CMD_VALUE_WRITE);
        host.sendByte(v[7:0]);
        host.sendByte(v[15:8]);
        expectBusy(ok);
        if (ok)
            {mem[17], mem[16], mem[19], mem[18]} = {v, v};
        for (int a = 16; a < 20; a++)
            readByte(7'(a));
    endtask
    // Main sequence
    initial
    begin
        locked = 1'b0;
        for (int i = 0; i < 128; i++)
            mem[i] = (i < 4) ? PROD[8 * i +: 8] : 8'hFF;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        sendCmd(card_eeprom_pkg::CMD_LOCK);
        expectBusy(1'b0);
        repeat (PWR) @(posedge clk);
        foreach (rdList[i])
            readByte(rdList[i]);
        foreach (corner[i])
            doWrite(corner[i][10:7], corner[i][6:0], rnd());
        for (int i = 0; i < 8; i++)
        begin
            s = rnd();
            doWrite(s[7] ? 4'h4 : 4'h1, s[6:0], rnd());
        end
        sendCmd(4'h1);
        host.sendByte(8'h00);
        host.sendByte(8'h20);
        host.sendByte(8'h3C);
        host.sendByte(8'h80);
        mem[32] = 8'h3C;
        expectBusy(1'b1);
        readByte(7'h20);
        doValue(16'h1234);
        doValue(16'h1234);
        doValue(16'h8000);
        doValue(16'h1233);
        sendCmd(card_eeprom_pkg::CMD_IDLE);
        expectBusy(1'b0);
        sendCmd(card_eeprom_pkg::CMD_LOCK);
        expectBusy(1'b1);
        locked = 1'b1;
        sendCmd(card_eeprom_pkg::CMD_LOCK);
        expectBusy(1'b0);
        doWrite(4'h4, 7'h05, 8'h77);
        sendCmd(4'h1);
        host.sendByte(8'h00);
        host.sendByte(8'h40);
        host.sendByte(8'h99);
        chipSelect <= 1'b0;
        repeat (6) @(posedge clk);
        check({6'h00, writeBusy, dataLineOe}, 8'h00);
        chipSelect <= 1'b1;
        repeat (4) @(posedge clk);
        readByte(7'h40);
        report_and_stop();
    end
endmodule // tb_prepaid_card_eeprom
